// *** core/lcd_cascade_pkg.sv ***
`default_nettype none

package lcd_cascade_pkg;

  // system clock
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned CLK_FREQ_HZ   = 50_000_000;

  // internal oscillator, typical frequency on the clock pin
  localparam int unsigned OSC_FREQ_HZ     = 3500;
  localparam int unsigned OSC_HALF_CYCLES = CLK_FREQ_HZ / (2 * OSC_FREQ_HZ);

  // least low time of the sync line
  localparam int unsigned SYNC_LOW_NS     = 100_000;
  localparam int unsigned SYNC_LOW_CYCLES = (SYNC_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // oscillator ticks in one backplane phase
  localparam int unsigned PHASE_TICKS = 6;

  // register bus
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;

  localparam logic [ADDR_W-1:0] CTRL_OFFSET   = 4'h0;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 4'h4;
  localparam logic [ADDR_W-1:0] SUBADDR_OFFSET = 4'h8;

  // control register fields
  localparam int unsigned CTRL_ENABLE_BIT = 0;
  localparam int unsigned CTRL_MUX_LSB    = 1;
  localparam int unsigned CTRL_SA_BIT     = 3;
  localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;

  // multiplex modes: active backplanes minus one
  typedef enum logic [1:0] {
    MUX_STATIC,
    MUX_DUPLEX,
    MUX_TRIPLEX,
    MUX_QUAD
  } mux_mode_e;

endpackage

`default_nettype wire

// *** core/lcd_clock_source.sv ***
`default_nettype none

// picks the frame time base: divided internal oscillator or the clock pin
module lcd_clock_source #(
  parameter int unsigned HALF_CYCLES = lcd_cascade_pkg::OSC_HALF_CYCLES
) (
  // clock and reset
  input  wire logic i_clock,
  input  wire logic i_nrst,
  // mode
  input  wire logic i_ext_select,
  input  wire logic i_enable,
  // clock pin
  input  wire logic i_clk_pin_in,
  output logic      o_clk_out,
  output logic      o_clk_oe,
  // time base
  output logic      o_tick
);
  import lcd_cascade_pkg::*;

  localparam int unsigned CNT_W = $clog2(HALF_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(HALF_CYCLES - 1);

  logic [CNT_W-1:0] div_reg;
  logic             osc_reg;
  logic             pin_prev_reg;
  logic             oe_reg;
  logic             osc_wrap;
  logic             osc_rise;
  logic             pin_rise;

  // internal oscillator model: one tick per full period
  assign osc_wrap = (div_reg == CNT_LAST);
  assign osc_rise = osc_wrap && !osc_reg;
  assign pin_rise = i_clk_pin_in && !pin_prev_reg;

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      div_reg      <= '0;
      osc_reg      <= 1'b0;
      pin_prev_reg <= 1'b0;
      oe_reg       <= 1'b0;
    end else begin
      div_reg      <= osc_wrap ? '0 : div_reg + CNT_W'(1);
      osc_reg      <= osc_wrap ? !osc_reg : osc_reg;
      pin_prev_reg <= i_clk_pin_in;
      oe_reg       <= !i_ext_select && i_enable;
    end
  end

  // external mode times the frame from the pin's rising edges only
  assign o_tick    = i_ext_select ? pin_rise : osc_rise;
  assign o_clk_out = osc_reg;
  assign o_clk_oe  = oe_reg;

endmodule

`default_nettype wire

// *** core/lcd_cascade_sync.sv ***
// Behaviour
// - device answers when slave bit and two subaddress pins match the addressed device
// - sync pin is two-way; output is open drain with pull-up
// - assert sync at start of the last active backplane phase of each frame; static mode never asserts
// - while not asserting, watch the sync line for other devices' assertions
// - first asserter restores alignment; others jump to its backplane timing
// - after reset every device starts at the same frame position
// - select low: run on internal oscillator and drive it out on clock pin
// - select high: take timing from the external clock pin
// - display disabled stops the clock pin output as well
// - acknowledge leaves on its own line, apart from serial data input
`default_nettype none

module lcd_cascade_sync #(
  parameter int unsigned OSC_HALF  = lcd_cascade_pkg::OSC_HALF_CYCLES,
  parameter int unsigned SYNC_LOW  = lcd_cascade_pkg::SYNC_LOW_CYCLES,
  parameter int unsigned PH_TICKS  = lcd_cascade_pkg::PHASE_TICKS
) (
  // clock and reset
  input  wire logic                                i_clock,
  input  wire logic                                i_nrst,
  // register port
  input  wire logic [lcd_cascade_pkg::ADDR_W-1:0]  i_addr,
  input  wire logic [lcd_cascade_pkg::DATA_W-1:0]  i_wdata,
  input  wire logic                                i_write,
  input  wire logic                                i_read,
  output logic      [lcd_cascade_pkg::DATA_W-1:0]  o_rdata,
  // hardware strap pins
  input  wire logic                                i_hw_subaddr_bit0,
  input  wire logic                                i_hw_subaddr_bit1,
  input  wire logic                                i_clock_source_select,
  // address check from the serial front end
  input  wire logic                                i_cmd_valid,
  input  wire logic                                i_cmd_slave_bit,
  input  wire logic [1:0]                          i_cmd_subaddr,
  output logic                                     o_addr_match,
  // acknowledge line, open drain
  input  wire logic                                i_ack_request,
  output logic                                     o_ack_out_line_out,
  output logic                                     o_ack_out_line_oe,
  // cascade sync line, open drain, active low
  input  wire logic                                i_sync_n_in,
  output logic                                     o_sync_n_out,
  output logic                                     o_sync_n_oe,
  // clock pin, two way
  input  wire logic                                i_clk_pin_in,
  output logic                                     o_clk_pin_out,
  output logic                                     o_clk_pin_oe,
  // backplane timing
  output logic      [1:0]                          o_bp_phase,
  output logic                                     o_backplane_out_0,
  output logic                                     o_frame_start
);
  import lcd_cascade_pkg::*;

  localparam int unsigned TK_W = $clog2(PH_TICKS + 1);
  localparam int unsigned SL_W = $clog2(SYNC_LOW + 1);
  localparam logic [TK_W-1:0] TK_LAST = TK_W'(PH_TICKS - 1);
  localparam logic [SL_W-1:0] SL_LOAD = SL_W'(SYNC_LOW - 1);

  // ---------------------------------------------------------------
  // control and status registers
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] ctrl_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic [DATA_W-1:0] status_word;
  logic [DATA_W-1:0] subaddr_word;
  logic              hit_ctrl;
  logic              hit_status;
  logic              hit_subaddr;
  logic              display_enable;
  logic              slave_bit;
  mux_mode_e         mux_mode;

  // address decode
  assign hit_ctrl    = (i_addr == CTRL_OFFSET);
  assign hit_status  = (i_addr == STATUS_OFFSET);
  assign hit_subaddr = (i_addr == SUBADDR_OFFSET);

  // control fields
  assign display_enable = ctrl_reg[CTRL_ENABLE_BIT];
  assign mux_mode       = mux_mode_e'(ctrl_reg[CTRL_MUX_LSB +: 2]);
  assign slave_bit      = ctrl_reg[CTRL_SA_BIT];

  // ---------------------------------------------------------------
  // frame state
  // ---------------------------------------------------------------
  logic [1:0]      phase_reg;
  logic [1:0]      phase_next;
  logic [TK_W-1:0] tick_cnt_reg;
  logic [TK_W-1:0] tick_cnt_next;
  logic [SL_W-1:0] low_cnt_reg;
  logic [SL_W-1:0] low_cnt_next;
  logic            sync_drive_reg;
  logic            sync_prev_reg;
  logic            frame_start_reg;
  logic            ack_reg;
  logic            tick;
  logic            last_phase_wrap;
  logic            phase_end;
  logic            enter_last;
  logic            sync_fall;
  logic            realign;
  logic [1:0]      last_phase;
  logic            osc_clk;
  logic            osc_oe;

  // time base from the internal divider or the clock pin
  lcd_clock_source #(
    .HALF_CYCLES (OSC_HALF)
  ) u_clock_source (
    .i_clock      (i_clock),
    .i_nrst       (i_nrst),
    .i_ext_select (i_clock_source_select),
    .i_enable     (display_enable),
    .i_clk_pin_in (i_clk_pin_in),
    .o_clk_out    (osc_clk),
    .o_clk_oe     (osc_oe),
    .o_tick       (tick)
  );

  // the pin is only driven in internal mode, and only while displaying
  assign o_clk_pin_out = osc_clk;
  assign o_clk_pin_oe  = osc_oe;

  // ---------------------------------------------------------------
  // addressing and acknowledge
  // ---------------------------------------------------------------
  // the slave bit picks the cluster of four, the pins the device within it
  assign o_addr_match = i_cmd_valid && (i_cmd_slave_bit == slave_bit)
                     && (i_cmd_subaddr == {i_hw_subaddr_bit1, i_hw_subaddr_bit0});

  // acknowledge pulls its own line low; data input is never driven here
  assign o_ack_out_line_out = 1'b0;
  assign o_ack_out_line_oe  = ack_reg;

  // ---------------------------------------------------------------
  // backplane sequencing
  // ---------------------------------------------------------------
  // last active phase index equals the mux mode encoding
  assign last_phase      = mux_mode;
  assign phase_end       = tick && (tick_cnt_reg == TK_LAST);
  assign last_phase_wrap = phase_end && (phase_reg == last_phase);

  // another device's falling edge is only heard while our driver is off
  assign sync_fall = !sync_drive_reg && sync_prev_reg && !i_sync_n_in;
  // follow the first asserter unless already in the last phase ourselves
  assign realign   = sync_fall && (phase_reg != last_phase);

  // entering the last phase starts our own assertion
  assign enter_last = realign
                   || (phase_end && !last_phase_wrap
                       && ((phase_reg + 2'd1) == last_phase));

  always_comb begin
    phase_next    = phase_reg;
    tick_cnt_next = tick_cnt_reg;
    if (realign) begin
      // jump to the start of the last phase, like the asserting device
      phase_next    = last_phase;
      tick_cnt_next = '0;
    end else if (phase_reg > last_phase) begin
      // mux mode shrank below the current phase: restart the frame
      phase_next    = 2'd0;
      tick_cnt_next = '0;
    end else if (phase_end) begin
      phase_next    = last_phase_wrap ? 2'd0 : phase_reg + 2'd1;
      tick_cnt_next = '0;
    end else if (tick) begin
      tick_cnt_next = tick_cnt_reg + TK_W'(1);
    end
  end

  // low time: the counter holds the line SYNC_LOW - 1 cycles after assertion
  always_comb begin
    low_cnt_next = low_cnt_reg;
    if (enter_last) begin
      low_cnt_next = SL_LOAD;
    end else if (low_cnt_reg != '0) begin
      low_cnt_next = low_cnt_reg - SL_W'(1);
    end
  end

  // frame and sync state; reset puts every device at phase 0 together
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      phase_reg    <= 2'd0;
      tick_cnt_reg <= '0;
      low_cnt_reg  <= '0;
    end else begin
      phase_reg    <= phase_next;
      tick_cnt_reg <= tick_cnt_next;
      low_cnt_reg  <= low_cnt_next;
    end
  end

  // sync drive: static mode never asserts, having no entry into its last phase
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      sync_drive_reg  <= 1'b0;
      sync_prev_reg   <= 1'b1;
      frame_start_reg <= 1'b0;
    end else begin
      sync_drive_reg  <= enter_last || (low_cnt_next != '0)
                      || (phase_next == last_phase && !last_phase_wrap
                          && sync_drive_reg);
      sync_prev_reg   <= i_sync_n_in;
      frame_start_reg <= last_phase_wrap;
    end
  end

  // open drain: only ever drive low, release lets the pull-up win
  assign o_sync_n_out = 1'b0;
  assign o_sync_n_oe  = sync_drive_reg;

  // backplane view of the frame
  assign o_bp_phase        = phase_reg;
  assign o_backplane_out_0 = (phase_reg == 2'd0);
  assign o_frame_start     = frame_start_reg;

  // ---------------------------------------------------------------
  // register access
  // ---------------------------------------------------------------
  assign status_word  = {2'b00, i_clock_source_select, !i_sync_n_in,
                         sync_drive_reg, display_enable, phase_reg};
  assign subaddr_word = {5'b00000, slave_bit, i_hw_subaddr_bit1, i_hw_subaddr_bit0};

  // unmapped addresses read as zero
  always_comb begin
    rdata_next = '0;
    if (!i_read) begin
      rdata_next = '0;
    end else if (hit_ctrl) begin
      rdata_next = ctrl_reg;
    end else if (hit_status) begin
      rdata_next = status_word;
    end else if (hit_subaddr) begin
      rdata_next = subaddr_word;
    end
  end

  // control write and one-cycle read data; ack is a registered level
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      ctrl_reg  <= CTRL_RESET;
      rdata_reg <= '0;
      ack_reg   <= 1'b0;
    end else begin
      if (i_write && hit_ctrl) begin
        ctrl_reg <= i_wdata;
      end
      rdata_reg <= rdata_next;
      ack_reg   <= i_ack_request;
    end
  end

  assign o_rdata = rdata_reg;

endmodule

`default_nettype wire

// *** sim/lcd_cascade_sync_monitor.sv ***
`default_nettype none

module lcd_cascade_sync_monitor #(
  parameter int unsigned SYNC_LOW = 3
) (
  // clock and reset
  input wire logic       i_clock,
  input wire logic       i_nrst,
  // address check and acknowledge
  input wire logic       i_hw_subaddr_bit0,
  input wire logic       i_hw_subaddr_bit1,
  input wire logic       i_cmd_valid,
  input wire logic [1:0] i_cmd_subaddr,
  input wire logic       o_addr_match,
  input wire logic       i_ack_request,
  input wire logic       o_ack_out_line_out,
  input wire logic       o_ack_out_line_oe,
  // sync line and clock pin
  input wire logic       i_sync_n_in,
  input wire logic       o_sync_n_out,
  input wire logic       o_sync_n_oe,
  input wire logic       i_clock_source_select,
  input wire logic       o_clk_pin_oe,
  // backplane timing
  input wire logic [1:0] o_bp_phase,
  input wire logic       o_backplane_out_0,
  input wire logic       o_frame_start
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking mon_cb @(posedge i_clock);
  endclocking
  default disable iff (!i_nrst);

  // length of the own low drive; saturates so a stuck drive cannot wrap to a pass
  logic [15:0] low_len_reg;
  always_ff @(posedge i_clock) begin
    if (!i_nrst || !o_sync_n_oe) low_len_reg <= 16'h0000;
    else if (low_len_reg != 16'hFFFF) low_len_reg <= low_len_reg + 16'h0001;
  end

  ack_follows_a: assert property ($past(i_nrst) |-> o_ack_out_line_oe == $past(i_ack_request))
    else $error("ack enable does not follow request");
  ack_drain_a: assert property (o_ack_out_line_out == 1'b0)
    else $error("ack line driven high");
  sync_drain_a: assert property (o_sync_n_out == 1'b0)
    else $error("sync line driven high");
  match_sub_a: assert property ((!i_cmd_valid || i_cmd_subaddr !=
    {i_hw_subaddr_bit1, i_hw_subaddr_bit0}) |-> !o_addr_match)
    else $error("match without address");
  clk_ext_a: assert property ($past(i_nrst) && $past(i_clock_source_select) |-> !o_clk_pin_oe)
    else $error("clock pin driven in external mode");
  bp_zero_a: assert property (o_backplane_out_0 == (o_bp_phase == 2'h0))
    else $error("backplane 0 out of step");
  frame_pulse_a: assert property (o_frame_start |-> o_bp_phase == 2'h0 ##1 !o_frame_start)
    else $error("frame pulse wrong");
  realign_a: assert property ($fell(i_sync_n_in) && !o_sync_n_oe |=>
    o_sync_n_oe || $stable(o_bp_phase))
    else $error("no realign on sync");
  low_hold_a: assert property ($past(i_nrst) && $fell(o_sync_n_oe) |->
    low_len_reg >= 16'(SYNC_LOW))
    else $error("sync low too short");
  sync_entry_a: assert property ($rose(o_sync_n_oe) && o_bp_phase != 2'h0 |->
    $changed(o_bp_phase))
    else $error("sync not at phase entry");
endmodule

bind lcd_cascade_sync lcd_cascade_sync_monitor #(.SYNC_LOW(SYNC_LOW)) mon (
  .i_clock(i_clock), .i_nrst(i_nrst), .i_hw_subaddr_bit0(i_hw_subaddr_bit0),
  .i_hw_subaddr_bit1(i_hw_subaddr_bit1), .i_cmd_valid(i_cmd_valid),
  .i_cmd_subaddr(i_cmd_subaddr), .o_addr_match(o_addr_match), .i_ack_request(i_ack_request),
  .o_ack_out_line_out(o_ack_out_line_out), .o_ack_out_line_oe(o_ack_out_line_oe),
  .i_sync_n_in(i_sync_n_in), .o_sync_n_out(o_sync_n_out), .o_sync_n_oe(o_sync_n_oe),
  .i_clock_source_select(i_clock_source_select), .o_clk_pin_oe(o_clk_pin_oe),
  .o_bp_phase(o_bp_phase), .o_backplane_out_0(o_backplane_out_0),
  .o_frame_start(o_frame_start));

`default_nettype wire

// *** sim/lcd_peer_model.sv ***
`default_nettype none

// another cascaded driver: pulls sync on command and can supply the frame clock
module lcd_peer_model #(
  parameter int unsigned HALF = 10
) (
  // clock and commands
  input  wire logic i_clock,
  input  wire logic i_pull,
  input  wire logic i_clk_on,
  // pins
  output logic      o_sync_oe,
  output var logic  o_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned cnt = 0;

  // open drain: only pulls low, the pull-up restores the line
  assign o_sync_oe = i_pull;

  // half period scaled down to keep the run short; the clock stands still while off
  initial o_clk = 1'b0;
  always @(posedge i_clock) begin
    if (!i_clk_on) begin
      cnt <= 0;
    end else if (cnt == HALF - 1) begin
      o_clk <= ~o_clk;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

`default_nettype wire

// *** sim/tb_top.sv ***
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import lcd_cascade_pkg::*;
  localparam int OSCH = 4;
  localparam int PHT = 2;
  localparam int HALF = 10;
  logic i_clock = 1'b0;
  logic i_nrst = 1'b0;
  logic [ADDR_W-1:0] i_addr = '0;
  logic [DATA_W-1:0] i_wdata = '0;
  logic [DATA_W-1:0] o_rdata;
  logic i_write = 1'b0, i_read = 1'b0, b0 = 1'b0, b1 = 1'b1, sel = 1'b0;
  logic cv = 1'b0, cs = 1'b0, ack = 1'b0, pull = 1'b0, ckon = 1'b0, old;
  logic [1:0] csub = 2'h0, ph;
  logic match, ack_o, ack_oe, s_o, s_oe, c_o, c_oe, bp0, fs;
  wire logic p_oe, p_clk;
  // resolved wires: sync has a pull-up, clock pin shows whoever drives
  wire logic sync_n = !(s_oe && !s_o) && !p_oe;
  wire logic clk_pin = c_oe ? c_o : p_clk;
  int fail_count = 0, total_checks = 0, seed = 77036, n, c;

  always #10 i_clock = ~i_clock;

  lcd_cascade_sync #(.OSC_HALF(OSCH), .SYNC_LOW(3), .PH_TICKS(PHT)) dut (
    .i_clock(i_clock), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata), .i_hw_subaddr_bit0(b0),
    .i_hw_subaddr_bit1(b1), .i_clock_source_select(sel), .i_cmd_valid(cv),
    .i_cmd_slave_bit(cs), .i_cmd_subaddr(csub), .o_addr_match(match), .i_ack_request(ack),
    .o_ack_out_line_out(ack_o), .o_ack_out_line_oe(ack_oe), .i_sync_n_in(sync_n),
    .o_sync_n_out(s_o), .o_sync_n_oe(s_oe), .i_clk_pin_in(clk_pin), .o_clk_pin_out(c_o),
    .o_clk_pin_oe(c_oe), .o_bp_phase(ph), .o_backplane_out_0(bp0), .o_frame_start(fs));
  lcd_peer_model #(.HALF(HALF)) peer (.i_clock(i_clock), .i_pull(pull), .i_clk_on(ckon),
    .o_sync_oe(p_oe), .o_clk(p_clk));

  // expected match for {slave bit, strap1, strap0, cmd slave bit, cmd subaddr}
  function automatic logic exp_match(input logic v, input logic [5:0] k);
    return v && k[5] == k[2] && k[4:3] == k[1:0];
  endfunction

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_write <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge i_clock);
    i_read <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_read <= 1'b0;
    #1 chk(what, exp, o_rdata);
  endtask
  // counts cycles until the phase (k=0) or clock pin (k=1) changes; bounded
  task automatic gap(input logic k);
    logic [1:0] v0;
    v0 = k ? {1'b0, c_o} : ph;
    c = 0;
    do begin
      @(posedge i_clock);
      #1 c++;
    end while ((k ? {1'b0, c_o} : ph) === v0 && c < 2000);
    if (c >= 2000) begin
      fail_count++;
      results();
    end
  endtask
  task automatic wait_ph(input logic [1:0] p);
    n = 0;
    do begin
      @(posedge i_clock);
      #1 n++;
    end while (ph !== p && n < 2000);
    if (n >= 2000) begin
      fail_count++;
      results();
    end
  endtask
  task automatic results();
    if (fail_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // hang guard, well above the whole sequence
  initial begin
    #1_500_000;
    fail_count++;
    results();
  end

  initial begin
    repeat (8) @(posedge i_clock);
    i_nrst <= 1'b1;
    rd(CTRL_OFFSET, CTRL_RESET, "ctrl");
    rd(STATUS_OFFSET, 8'h00, "status");
    rd(SUBADDR_OFFSET, 8'h02, "subaddr");
    rd(4'hC, 8'h00, "unmapped");
    wr(STATUS_OFFSET, 8'hFF);
    rd(STATUS_OFFSET, 8'h00, "status ro");
    for (int m = 0; m < 4; m++) begin
      wr(CTRL_OFFSET, 8'(m) << CTRL_MUX_LSB);
      rd(CTRL_OFFSET, 8'(m) << CTRL_MUX_LSB, "ctrl mux");
    end
    // all slave bits, straps and command addresses, valid drawn at random
    for (int k = 0; k < 64; k++) begin
      wr(CTRL_OFFSET, 8'(k[5]) << CTRL_SA_BIT);
      {b1, b0, cs, csub} <= k[4:0];
      cv <= (k == 0) ? 1'b0 : 1'($random(seed));
      @(posedge i_clock);
      #1 chk("match", {7'h0, exp_match(cv, 6'(k))}, {7'h0, match});
    end
    cv <= 1'b0;
    for (int k = 0; k < 40; k++) begin
      @(posedge i_clock);
      old = ack;
      ack <= 1'($random(seed));
      #1 chk("ack oe", {7'h0, old}, {7'h0, ack_oe});
    end
    // internal oscillator, four backplanes
    wr(CTRL_OFFSET, 8'h07);
    repeat (2) @(posedge i_clock);
    #1 chk("clk oe", 8'h01, {7'h0, c_oe});
    gap(1'b1);
    gap(1'b1);
    chk("clk half", 8'(OSCH), 8'(c));
    wait_ph(2'h2);
    wait_ph(2'h3);
    chk("sync drive", 8'h01, {7'h0, s_oe});
    chk("sync wire", 8'h00, {7'h0, sync_n});
    wait_ph(2'h0);
    chk("frame start", 8'h01, {7'h0, fs});
    @(posedge i_clock);
    #1 chk("sync release", 8'h01, {7'h0, sync_n});
    wait_ph(2'h1);
    @(posedge i_clock);
    pull <= 1'b1;
    @(posedge i_clock);
    #1 chk("realign phase", 8'h03, {6'h0, ph});
    chk("realign drive", 8'h01, {7'h0, s_oe});
    repeat (2) @(posedge i_clock);
    pull <= 1'b0;
    wr(CTRL_OFFSET, 8'h06);
    repeat (2) @(posedge i_clock);
    #1 chk("clk off", 8'h00, {7'h0, c_oe});
    // external clock from the peer, enable sent as the clock starts
    @(posedge i_clock);
    sel <= 1'b1;
    ckon <= 1'b1;
    wr(CTRL_OFFSET, 8'h07);
    repeat (2) @(posedge i_clock);
    #1 chk("clk ext oe", 8'h00, {7'h0, c_oe});
    gap(1'b0);
    gap(1'b0);
    chk("ext phase", 8'(2 * HALF * PHT), 8'(c));
    // second reset in mid-run
    @(posedge i_clock);
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_nrst <= 1'b1;
    #1 chk("reset phase", 8'h00, {6'h0, ph});
    chk("reset drive", 8'h00, {7'h0, s_oe});
    rd(CTRL_OFFSET, CTRL_RESET, "ctrl after reset");
    results();
  end
endmodule

`default_nettype wire
